// file: src/acq_pkg.sv
// Constants, register map and state codes for the acquisition sequencer
`default_nettype none
package acq_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_CFG = 8'h04;
    localparam logic [7:0] OFF_PERIOD = 8'h08;
    localparam logic [7:0] OFF_TARGET = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_DATA = 8'h14;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;
    localparam logic [7:0] OFF_DIN = 8'h20;
    localparam logic [7:0] OFF_DOUT = 8'h24;
    // Command bits
    localparam int CMD_START = 0;
    localparam int CMD_STOP = 1;
    localparam int CMD_CLEAR = 2;
    // Configuration fields
    localparam int CFG_START_EXT = 0;
    localparam int CFG_START_FALL = 1;
    localparam int CFG_STOP_LO = 2;
    localparam int CFG_STOP_FALL = 4;
    localparam int CFG_CLK_EXT = 5;
    localparam int CFG_CLK_FALL = 6;
    localparam int CFG_RING = 7;
    localparam int CFG_NCH_LO = 8;
    localparam int CFG_W = 11;
    localparam logic [1:0] STOP_BY_COUNT = 2'h0;
    localparam logic [1:0] STOP_BY_EXT = 2'h1;
    localparam logic [1:0] STOP_BY_SW = 2'h2;
    // Interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_OVF = 1;
    localparam int IRQ_CTO = 2;
    localparam int IRQ_W = 3;
    // Digital input lines with trigger roles
    localparam int DIN_START = 0;
    localparam int DIN_STOP = 1;
    localparam int DIN_CLK = 2;
    localparam int DIO_W = 4;
    // Status fields
    localparam int STAT_FILL_LO = 16;
    localparam int STAT_FULL = 2;
    localparam int STAT_EMPTY = 3;
    // Sizes
    localparam int SAMPLE_W = 16;
    localparam int NCH = 8;
    localparam int CH_W = 3;
    localparam int BUF_DEPTH = 8192;
    localparam int BUF_AW = 13;
    localparam int TIMER_W = 24;
    localparam int COUNT_W = 24;
    localparam int CNV_W = 8;
    // Timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int CONV_MAX_NS = 4000;
    localparam int CONV_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
    // Reset values
    localparam logic [TIMER_W-1:0] PERIOD_RST = 24'h00_0fa0;
    localparam logic [COUNT_W-1:0] TARGET_RST = 24'h00_0400;
    localparam logic [CFG_W-1:0] CFG_RST = 11'h000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARM = 2'b01,
        ST_WAIT = 2'b10,
        ST_CONV = 2'b11
    } acq_state_e;
endpackage
`default_nettype wire

// file: src/edge_pick.sv
// Selectable rising or falling edge detector on a synchronous input line
`default_nettype none
module edge_pick
    import acq_pkg::*;
#(
    parameter logic IDLE_LEVEL = 1'b0
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic line_i,
    input wire logic fall_i,
    output logic event_o
);
    logic prev;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            prev <= IDLE_LEVEL;
        end
        else
        begin
            prev <= line_i;
        end
    end

    // One pulse per chosen edge; the line is already in this clock domain
    assign event_o = fall_i ? (prev && !line_i) : (!prev && line_i);
endmodule
`default_nettype wire

// file: src/sample_buffer.sv
// Sample store of fixed depth that runs as a FIFO or as a ring
`default_nettype none
module sample_buffer
    import acq_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clear_i,
    input wire logic ring_i,
    input wire logic push_i,
    input wire logic [SAMPLE_W-1:0] data_i,
    input wire logic pop_i,
    output logic [SAMPLE_W-1:0] q_o,
    output logic [BUF_AW:0] count_o,
    output logic full_o,
    output logic empty_o,
    output logic ovf_o
);
    logic [SAMPLE_W-1:0] mem [BUF_DEPTH];
    logic [BUF_AW-1:0] wp;
    logic [BUF_AW-1:0] rp;
    logic do_pop;
    logic do_push;
    logic over;

    assign full_o = (count_o == (BUF_AW+1)'(BUF_DEPTH));
    assign empty_o = (count_o == '0);
    assign do_pop = pop_i && !empty_o;
    assign do_push = push_i && (!full_o || ring_i || do_pop);
    // Ring drops the oldest sample; FIFO drops the new one and flags it
    assign over = push_i && full_o && ring_i && !do_pop;
    assign ovf_o = push_i && full_o && !ring_i && !do_pop;

    always_ff @(posedge clk_i)
    begin
        if (do_push)
        begin
            mem[wp] <= data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wp <= '0;
            rp <= '0;
            count_o <= '0;
            q_o <= '0;
        end
        else if (clear_i)
        begin
            wp <= '0;
            rp <= '0;
            count_o <= '0;
        end
        else
        begin
            if (do_push)
            begin
                wp <= wp + BUF_AW'(1);
            end
            if (do_pop || over)
            begin
                rp <= rp + BUF_AW'(1);
            end
            if (do_pop)
            begin
                q_o <= mem[rp];
            end
            if (do_push && !do_pop && !over)
            begin
                count_o <= count_o + (BUF_AW+1)'(1);
            end
            else if (do_pop && !do_push)
            begin
                count_o <= count_o - (BUF_AW+1)'(1);
            end
        end
    end
endmodule
`default_nettype wire

// file: src/acq_sequencer.sv
// Acquisition sequencer: triggers, pacing, channel scan, buffer and registers
//
// The implementer's own choices: the strobed register port and the address map.
`default_nettype none
module acq_sequencer
    import acq_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [31:0] rdata_o,
    output logic irq_o,
    input wire logic [DIO_W-1:0] din_i,
    output logic [DIO_W-1:0] dout_o,
    output logic adc_start_o,
    output logic [CH_W-1:0] adc_chan_o,
    input wire logic adc_done_i,
    input wire logic [SAMPLE_W-1:0] adc_data_i
);
    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [CFG_W-1:0] cfg;
    logic [TIMER_W-1:0] period;
    logic [COUNT_W-1:0] target;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_set;
    acq_state_e state;
    logic stop_pend;
    logic [COUNT_W-1:0] scans;
    logic [COUNT_W-1:0] next_scans;
    logic [TIMER_W-1:0] tcnt;
    logic [CNV_W-1:0] ccnt;
    logic [31:0] rd_reg;
    logic rd_buf;
    logic wr_cmd;
    logic sw_start;
    logic sw_stop;
    logic buf_clear;
    logic start_ev;
    logic stop_ev;
    logic clk_ev;
    logic tick;
    logic ext_stop;
    logic halt;
    logic last_ch;
    logic scan_end;
    logic conv_to;
    logic run_end;
    logic push;
    logic pop;
    logic ovf;
    logic buf_full;
    logic buf_empty;
    logic [SAMPLE_W-1:0] buf_q;
    logic [BUF_AW:0] buf_count;
    logic [DIO_W-1:0] din_view;
    logic [1:0] stop_sel;
    logic [CH_W-1:0] last_chan;

    ////////////////////////////////////////////////////////////////////////////
    // Command decode
    assign wr_cmd = we_i && (addr_i == OFF_CMD);
    assign sw_start = wr_cmd && wdata_i[CMD_START];
    assign sw_stop = wr_cmd && wdata_i[CMD_STOP];
    assign buf_clear = wr_cmd && wdata_i[CMD_CLEAR];
    assign stop_sel = cfg[CFG_STOP_LO +: 2];
    assign last_chan = cfg[CFG_NCH_LO +: CH_W];

    ////////////////////////////////////////////////////////////////////////////
    // Trigger and clock lines
    edge_pick start_edge
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .line_i(din_i[DIN_START]),
        .fall_i(cfg[CFG_START_FALL]),
        .event_o(start_ev)
    );

    edge_pick stop_edge
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .line_i(din_i[DIN_STOP]),
        .fall_i(cfg[CFG_STOP_FALL]),
        .event_o(stop_ev)
    );

    edge_pick clock_edge
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .line_i(din_i[DIN_CLK]),
        .fall_i(cfg[CFG_CLK_FALL]),
        .event_o(clk_ev)
    );

    assign ext_stop = (stop_sel == STOP_BY_EXT) && stop_ev;
    // Software stop is honoured under every stop selection so a run can be aborted
    assign halt = sw_stop || ext_stop;
    assign tick = cfg[CFG_CLK_EXT] ? clk_ev : (tcnt == '0);

    ////////////////////////////////////////////////////////////////////////////
    // Internal pacing timer, period value P gives one tick every P+1 cycles
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tcnt <= PERIOD_RST;
        end
        else if (state == ST_IDLE || state == ST_ARM || tcnt == '0)
        begin
            tcnt <= period;
        end
        else
        begin
            tcnt <= tcnt - TIMER_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Run sequencer
    assign last_ch = (adc_chan_o == last_chan);
    assign scan_end = (state == ST_CONV) && adc_done_i && last_ch;
    assign next_scans = scans + COUNT_W'(1);
    // A converter that never answers must not hang the run
    assign conv_to = (state == ST_CONV) && !adc_done_i && (ccnt == CNV_W'(CONV_CYC));
    assign push = (state == ST_CONV) && adc_done_i;

    always_comb
    begin
        run_end = 1'b0;
        if ((state == ST_WAIT || state == ST_ARM) && halt)
        begin
            run_end = 1'b1;
        end
        else if (conv_to)
        begin
            run_end = 1'b1;
        end
        else if (scan_end)
        begin
            run_end = stop_pend || halt
                || (stop_sel == STOP_BY_COUNT && next_scans == target);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state <= ST_IDLE;
            stop_pend <= 1'b0;
            scans <= '0;
            adc_chan_o <= '0;
            adc_start_o <= 1'b0;
            ccnt <= '0;
        end
        else
        begin
            adc_start_o <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    stop_pend <= 1'b0;
                    scans <= '0;
                    if (sw_start)
                    begin
                        state <= cfg[CFG_START_EXT] ? ST_ARM : ST_WAIT;
                    end
                end
                ST_ARM:
                begin
                    if (halt)
                    begin
                        state <= ST_IDLE;
                    end
                    else if (start_ev)
                    begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    if (halt)
                    begin
                        state <= ST_IDLE;
                    end
                    else if (tick)
                    begin
                        state <= ST_CONV;
                        adc_chan_o <= '0;
                        adc_start_o <= 1'b1;
                        ccnt <= '0;
                    end
                end
                ST_CONV:
                begin
                    // A stop during a scan lets the scan finish first
                    if (halt)
                    begin
                        stop_pend <= 1'b1;
                    end
                    ccnt <= ccnt + CNV_W'(1);
                    if (conv_to)
                    begin
                        state <= ST_IDLE;
                    end
                    else if (adc_done_i && !last_ch)
                    begin
                        adc_chan_o <= adc_chan_o + CH_W'(1);
                        adc_start_o <= 1'b1;
                        ccnt <= '0;
                    end
                    else if (scan_end)
                    begin
                        scans <= next_scans;
                        state <= run_end ? ST_IDLE : ST_WAIT;
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sample buffer
    assign pop = re_i && (addr_i == OFF_DATA);

    sample_buffer store
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .clear_i(buf_clear),
        .ring_i(cfg[CFG_RING]),
        .push_i(push),
        .data_i(adc_data_i),
        .pop_i(pop),
        .q_o(buf_q),
        .count_o(buf_count),
        .full_o(buf_full),
        .empty_o(buf_empty),
        .ovf_o(ovf)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register writes
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cfg <= CFG_RST;
            period <= PERIOD_RST;
            target <= TARGET_RST;
            irq_mask <= '0;
            dout_o <= '0;
        end
        else if (we_i)
        begin
            if (addr_i == OFF_CFG)
            begin
                cfg <= wdata_i[CFG_W-1:0];
            end
            else if (addr_i == OFF_PERIOD)
            begin
                period <= wdata_i[TIMER_W-1:0];
            end
            else if (addr_i == OFF_TARGET)
            begin
                target <= wdata_i[COUNT_W-1:0];
            end
            else if (addr_i == OFF_IRQ_MASK)
            begin
                irq_mask <= wdata_i[IRQ_W-1:0];
            end
            else if (addr_i == OFF_DOUT)
            begin
                dout_o <= wdata_i[DIO_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status, write one to clear; a new event wins over the clear
    always_comb
    begin
        irq_set = '0;
        irq_set[IRQ_DONE] = run_end;
        irq_set[IRQ_OVF] = ovf;
        irq_set[IRQ_CTO] = conv_to;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            irq_stat <= '0;
        end
        else if (we_i && addr_i == OFF_IRQ_STAT)
        begin
            irq_stat <= (irq_stat & ~wdata_i[IRQ_W-1:0]) | irq_set;
        end
        else
        begin
            irq_stat <= irq_stat | irq_set;
        end
    end

    assign irq_o = |(irq_stat & irq_mask);

    ////////////////////////////////////////////////////////////////////////////
    // Register reads
    always_comb
    begin
        din_view = din_i;
        din_view[DIN_START] = din_i[DIN_START] && !cfg[CFG_START_EXT];
        din_view[DIN_STOP] = din_i[DIN_STOP] && (stop_sel != STOP_BY_EXT);
        din_view[DIN_CLK] = din_i[DIN_CLK] && !cfg[CFG_CLK_EXT];
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rd_reg <= '0;
            rd_buf <= 1'b0;
        end
        else
        begin
            rd_reg <= '0;
            rd_buf <= pop;
            if (re_i)
            begin
                if (addr_i == OFF_CFG)
                begin
                    rd_reg <= 32'(cfg);
                end
                else if (addr_i == OFF_PERIOD)
                begin
                    rd_reg <= 32'(period);
                end
                else if (addr_i == OFF_TARGET)
                begin
                    rd_reg <= 32'(target);
                end
                else if (addr_i == OFF_STATUS)
                begin
                    rd_reg <= {2'b00, buf_count, 12'h000, buf_empty, buf_full, state};
                end
                else if (addr_i == OFF_IRQ_STAT)
                begin
                    rd_reg <= 32'(irq_stat);
                end
                else if (addr_i == OFF_IRQ_MASK)
                begin
                    rd_reg <= 32'(irq_mask);
                end
                else if (addr_i == OFF_DIN)
                begin
                    rd_reg <= 32'(din_view);
                end
                else if (addr_i == OFF_DOUT)
                begin
                    rd_reg <= 32'(dout_o);
                end
            end
        end
    end

    // Both sources are flops; the buffer word bypasses rd_reg to keep one cycle
    assign rdata_o = rd_buf ? 32'(buf_q) : rd_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_conv_time_bound:
    assert property (state == ST_CONV |-> ccnt <= CNV_W'(CONV_CYC))
    else $error("conversion wait exceeded bound");

    a_ring_keeps_full:
    assert property (push && buf_full && cfg[CFG_RING] && !pop && !buf_clear
        |=> buf_full && !irq_set[IRQ_OVF])
    else $error("ring mode lost fill on overwrite");

    a_sw_start_run:
    assert property (state == ST_IDLE && sw_start && !cfg[CFG_START_EXT] |=> state == ST_WAIT)
    else $error("software start ignored");

    a_ext_start_arm:
    assert property (state == ST_ARM && start_ev && !halt |=> state == ST_WAIT)
    else $error("external start edge ignored");

    a_tick_starts_scan:
    assert property (state == ST_WAIT && tick && !halt
        |=> state == ST_CONV && adc_start_o && adc_chan_o == '0)
    else $error("pace tick did not start a scan");

    a_ext_stop_ends:
    assert property (state == ST_WAIT && ext_stop |=> state == ST_IDLE && irq_stat[IRQ_DONE])
    else $error("external stop did not end run");

    a_count_stop:
    assert property (scan_end && stop_sel == STOP_BY_COUNT && next_scans == target
        |=> state == ST_IDLE)
    else $error("sample count did not end run");

    a_autonomous_scan:
    // A stop that arrives while waiting is a legal cause to leave the run
    assert property (scan_end && !run_end
        |=> state == ST_WAIT ##1 (state != ST_IDLE || $past(halt)))
    else $error("run stopped without cause");

    a_fifo_overflow:
    assert property (push && buf_full && !cfg[CFG_RING] && !pop |=> irq_stat[IRQ_OVF])
    else $error("fifo overflow not flagged");

    a_din_masked:
    assert property (re_i && addr_i == OFF_DIN && cfg[CFG_CLK_EXT] |=> !rdata_o[DIN_CLK])
    else $error("clock line visible as input");

    a_dout_level:
    assert property (we_i && addr_i == OFF_DOUT |=> dout_o == $past(wdata_i[DIO_W-1:0]))
    else $error("output lines do not follow write");
endmodule
`default_nettype wire

// file: verif/adc_model.sv
// Converter model that answers conversion starts after a chosen delay
`default_nettype none
module adc_model
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic [2:0] chan_i,
    input wire logic [1:0] mode_i,
    output logic done_o,
    output logic [15:0] data_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int left;
    // Mode 0 fast, 1 just inside the conversion limit, 2 never answers
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            left <= 0;
            done_o <= 1'b0;
            data_o <= 16'h0000;
        end
        else
        begin
            done_o <= 1'b0;
            // Data toggles outside done so a late sample is never lucky
            data_o <= ~data_o;
            if (start_i && mode_i != 2'd2)
                left <= (mode_i == 2'd1) ? 150 : 2;
            else if (left > 0)
                left <= left - 1;
            if (left == 1)
            begin
                done_o <= 1'b1;
                data_o <= {chan_i, 13'h00ab};
            end
        end
    end
endmodule
`default_nettype wire

// file: verif/sampling_trigger_buffer_control_bench.sv
// Self-checking bench for the acquisition sequencer
`default_nettype none
module sampling_trigger_buffer_control_bench
    import acq_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic we_i = 1'b0;
    logic re_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0000_0000;
    logic [31:0] rdata_o;
    logic [3:0] din_i = 4'h0;
    logic [3:0] dout_o;
    logic irq_o;
    logic adc_start_o;
    logic adc_done_i;
    logic [2:0] adc_chan_o;
    logic [15:0] adc_data_i;
    logic [1:0] mode = 2'd0;
    logic [31:0] v;
    int err_count = 0;
    int compares = 0;
    int i;
    logic [7:0] ra [9] = '{OFF_CFG, OFF_PERIOD, OFF_TARGET, OFF_STATUS, OFF_IRQ_STAT,
        OFF_IRQ_MASK, OFF_DOUT, OFF_DIN, 8'h30};
    logic [31:0] rx [9] = '{32'h0000_0000, 32'h0000_0fa0, 32'h0000_0400, 32'h0000_0008,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

    acq_sequencer dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .irq_o(irq_o), .din_i(din_i),
        .dout_o(dout_o), .adc_start_o(adc_start_o), .adc_chan_o(adc_chan_o),
        .adc_done_i(adc_done_i), .adc_data_i(adc_data_i));
    adc_model model (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(adc_start_o),
        .chan_i(adc_chan_o), .mode_i(mode), .done_o(adc_done_i), .data_o(adc_data_i));

    initial
        forever #12.5 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        we_i <= 1'b1;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        re_i <= 1'b1;
        @(posedge clk_i);
        re_i <= 1'b0;
        @(negedge clk_i);
        d = rdata_o;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(d, exp);
    endtask
    // Lines settle for several cycles so each edge is seen once
    task automatic pin(input logic [3:0] d);
        @(posedge clk_i);
        din_i <= d;
        repeat (6) @(posedge clk_i);
    endtask
    task automatic wait_irq(input int b, input int lim);
        logic [31:0] s;
        int n;
        s = 32'h0000_0000;
        for (n = 0; n < lim && s[b] !== 1'b1; n++)
            rd(OFF_IRQ_STAT, s);
        if (s[b] !== 1'b1)
        begin
            err_count++;
            $display("wrong value at %0t: event flag never set", $time);
        end
    endtask
    task automatic finish_test();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // The full FIFO run dominates the run time
    initial
    begin
        #2400000;
        err_count++;
        finish_test();
    end

    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (i = 0; i < 9; i++)
            rdc(ra[i], rx[i]);
        wr(OFF_DOUT, 32'h0000_0005);
        @(negedge clk_i);
        chk({28'h0, dout_o}, 32'h0000_0005);
        // Software start, timer pacing, two channels, stop after two scans
        wr(OFF_CFG, 32'h0000_0100);
        wr(OFF_PERIOD, 32'h0000_0009);
        wr(OFF_TARGET, 32'h0000_0002);
        wr(OFF_IRQ_MASK, 32'h0000_0001);
        wr(OFF_CMD, 32'h0000_0001);
        wait_irq(IRQ_DONE, 200);
        @(negedge clk_i);
        chk({31'h0, irq_o}, 32'h0000_0001);
        rdc(OFF_STATUS, 32'h0004_0000);
        for (i = 0; i < 4; i++)
            rdc(OFF_DATA, {16'h0000, 3'(i % 2), 13'h00ab});
        rdc(OFF_STATUS, 32'h0000_0008);
        wr(OFF_IRQ_STAT, 32'h0000_0001);
        @(negedge clk_i);
        chk({31'h0, irq_o}, 32'h0000_0000);
        // External falling start, rising clock, rising stop
        wr(OFF_CFG, 32'h0000_0027);
        pin(4'hf);
        rdc(OFF_DIN, 32'h0000_0008);
        pin(4'h9);
        wr(OFF_CMD, 32'h0000_0001);
        rdc(OFF_STATUS, 32'h0000_0009);
        pin(4'h8);
        rdc(OFF_STATUS, 32'h0000_000a);
        pin(4'hc);
        pin(4'h8);
        pin(4'hc);
        pin(4'h8);
        rdc(OFF_STATUS, 32'h0002_0002);
        pin(4'ha);
        rdc(OFF_STATUS, 32'h0002_0000);
        // Software start, falling clock and falling stop edges
        wr(OFF_CFG, 32'h0000_0074);
        pin(4'hf);
        wr(OFF_CMD, 32'h0000_0001);
        pin(4'hb);
        rdc(OFF_STATUS, 32'h0003_0002);
        pin(4'h9);
        rdc(OFF_STATUS, 32'h0003_0000);
        // Eight channels until the FIFO refuses, then one ring scan
        wr(OFF_CMD, 32'h0000_0004);
        wr(OFF_IRQ_STAT, 32'h0000_0007);
        wr(OFF_CFG, 32'h0000_0700);
        wr(OFF_PERIOD, 32'h0000_0000);
        wr(OFF_TARGET, 32'h0000_0401);
        wr(OFF_IRQ_MASK, 32'h0000_0003);
        wr(OFF_CMD, 32'h0000_0001);
        wait_irq(IRQ_DONE, 20000);
        rdc(OFF_IRQ_STAT, 32'h0000_0003);
        rdc(OFF_STATUS, 32'h2000_0004);
        wr(OFF_IRQ_STAT, 32'h0000_0003);
        wr(OFF_CFG, 32'h0000_0780);
        wr(OFF_TARGET, 32'h0000_0001);
        wr(OFF_CMD, 32'h0000_0001);
        wait_irq(IRQ_DONE, 200);
        rdc(OFF_IRQ_STAT, 32'h0000_0001);
        rdc(OFF_STATUS, 32'h2000_0004);
        rdc(OFF_DATA, 32'h0000_00ab);
        // Converter never answers
        wr(OFF_CMD, 32'h0000_0004);
        wr(OFF_IRQ_STAT, 32'h0000_0007);
        mode <= 2'd2;
        wr(OFF_CFG, 32'h0000_0000);
        wr(OFF_CMD, 32'h0000_0001);
        wait_irq(IRQ_CTO, 200);
        rdc(OFF_IRQ_STAT, 32'h0000_0005);
        // Slow converter, software stop only
        wr(OFF_IRQ_STAT, 32'h0000_0007);
        mode <= 2'd1;
        wr(OFF_CFG, 32'h0000_0008);
        wr(OFF_CMD, 32'h0000_0001);
        repeat (400) @(posedge clk_i);
        wr(OFF_CMD, 32'h0000_0002);
        wait_irq(IRQ_DONE, 200);
        rdc(OFF_IRQ_STAT, 32'h0000_0001);
        rd(OFF_STATUS, v);
        chk(v & 32'h0000_0003, 32'h0000_0000);
        // Reset in mid-run
        wr(OFF_CMD, 32'h0000_0001);
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b0;
        @(negedge clk_i);
        chk({28'h0, dout_o}, 32'h0000_0000);
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        rdc(OFF_STATUS, 32'h0000_0008);
        finish_test();
    end
endmodule
`default_nettype wire
